// *** src/system_address_decoder.sv ***
/*
  System address decoder: one-hot slave selects, boot aliasing, execute
  protection, identification table, flash select latch and adaptor
  presence level for the interrupt lines.
  Assumes a single-outstanding request/response master; slaves answer
  with a ready pulse; the decoder itself answers unmapped accesses.
*/
// Summary of operation
// - block RAM window 8KB, executable
// - three 4KB processor debug/system windows
// - fixed read-only id table at top
// - peripherals decoded inside peripheral region
// - block RAM decoded inside memory region
// - no adaptor: instruction RAM at both aliases
// - no adaptor: boot from RAM at zero
// - adaptor: instruction RAM only at upper alias
// - adaptor: XIP flash decoded at zero
// - data RAM always at its base
// - fetches from data RAM refused
// - flash pins go to one controller
// - XIP reads, normal mode for writing
// - adaptor peripheral addresses fixed
// - boot map follows low alias bit
// - GPIO bit drives flash select
// - adaptor-present level on interrupt line 31
`timescale 1ns/10ps
`default_nettype none
module system_address_decoder
  import addr_map_pkg::*;
#(
  parameter int ID_DEPTH = ID_WORDS
) (
  input wire logic mclk,
  input wire logic rst_n,
  // processor request
  input wire logic reqValid,
  input wire logic [31:0] reqAddr,
  input wire logic reqWrite,
  input wire logic reqFetch,
  input wire logic [31:0] reqWdata,
  // slave selects and returns
  output logic [15:0] slaveSel,
  input wire logic slaveReady,
  input wire logic [31:0] slaveRdata,
  input wire logic slaveErr,
  // processor response
  output logic rspValid,
  output logic [31:0] rspRdata,
  output logic rspErr,
  // boot mapping to the core
  output logic [1:0] instrRamAliasConfig,
  // adaptor presence
  input wire logic adaptorPresent_n,
  input wire logic [IRQ_W-2:0] periphIrq,
  output logic [IRQ_W-1:0] coreIrq,
  // flash pins
  output logic flashCsN,
  output logic flashSck,
  output logic [3:0] flashDo,
  output logic [3:0] flashOe,
  input wire logic [3:0] flashDi,
  // xip controller side
  input wire logic xipCsN,
  input wire logic xipSck,
  input wire logic [3:0] xipDo,
  input wire logic [3:0] xipOe,
  output logic [3:0] xipDi,
  // normal-mode controller side
  input wire logic normCsN,
  input wire logic normSck,
  input wire logic [3:0] normDo,
  input wire logic [3:0] normOe,
  output logic [3:0] normDi,
  output logic flashSelNormal
);

  ////////////////////////////////////////////////////////////////////////
  // reset release and pin synchroniser

  logic rstMeta_reg, rstSync_reg;
  logic [2:0] presSync_reg;
  logic presentN_reg;
  logic presentN_next;

  // reset held low until two clean edges after release
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_reg <= 1'b0;
      rstSync_reg <= 1'b0;
    end else begin
      rstMeta_reg <= 1'b1;
      rstSync_reg <= rstMeta_reg;
    end
  end

  // presence pin: change accepted once stages two and three agree
  assign presentN_next = (presSync_reg[1] == presSync_reg[2]) ? presSync_reg[2] : presentN_reg;

  // resets to absent-adaptor (high) so the RAM boot map is the safe default
  always_ff @(posedge mclk or negedge rstSync_reg) begin
    if (!rstSync_reg) begin
      presSync_reg <= 3'h7;
      presentN_reg <= 1'b1;
    end else begin
      presSync_reg <= {presSync_reg[1:0], adaptorPresent_n};
      presentN_reg <= presentN_next;
    end
  end

  // software polls this level; it is not meant to raise an interrupt
  assign coreIrq = {presentN_reg, periphIrq};

  ////////////////////////////////////////////////////////////////////////
  // boot aliasing

  logic adaptorFitted;
  assign adaptorFitted = ~presentN_reg;
  // low alias on only without adaptor; upper alias tied high
  assign instrRamAliasConfig[ALIAS_LOW_BIT] = ~adaptorFitted;
  assign instrRamAliasConfig[ALIAS_HIGH_BIT] = 1'b1;

  ////////////////////////////////////////////////////////////////////////
  // address decode

  function automatic logic inRange(input logic [31:0] a, input logic [31:0] lo,
                                   input logic [31:0] hi);
    inRange = (a >= lo) && (a <= hi);
  endfunction

  function automatic logic inSlot(input logic [31:0] a, input logic [31:0] base,
                                  input logic [31:0] mask);
    inSlot = (a & mask) == base;
  endfunction

  logic hitLowAlias, hitHighAlias, hitDataRam, hitPeriph, hitMemRegion;
  logic hitBram, hitWatch, hitBreak, hitSysCtrl, hitIdTable;
  target_t target;

  assign hitLowAlias = inRange(reqAddr, INSTR_LOW_BASE, INSTR_LOW_LAST);
  assign hitHighAlias = inRange(reqAddr, INSTR_HIGH_BASE, INSTR_HIGH_LAST);
  assign hitDataRam = inRange(reqAddr, DATA_RAM_BASE, DATA_RAM_LAST);
  assign hitPeriph = inRange(reqAddr, PERIPH_BASE, PERIPH_LAST);
  assign hitMemRegion = inRange(reqAddr, MEM_REGION_BASE, MEM_REGION_LAST);
  assign hitBram = hitMemRegion && inRange(reqAddr, BRAM_BASE, BRAM_LAST);
  assign hitWatch = inSlot(reqAddr, WATCH_TRACE_BASE, SYS_WIN_MASK);
  assign hitBreak = inSlot(reqAddr, BREAKPOINT_BASE, SYS_WIN_MASK);
  assign hitSysCtrl = inSlot(reqAddr, SYS_CTRL_BASE, SYS_WIN_MASK);
  assign hitIdTable = inRange(reqAddr, ID_TABLE_BASE, ID_TABLE_LAST);

  // peripheral slots sit at fixed 64KB bases the adaptor firmware expects
  function automatic target_t periphTarget(input logic [31:0] a);
    logic [31:0] slot;
    slot = a & PERIPH_SLOT_MASK;
    unique case (slot)
      XIP_CTRL_BASE: periphTarget = TGT_XIP_CTRL;
      FLASH_SEL_GPIO_BASE: periphTarget = TGT_FLASH_SEL_GPIO;
      NORMAL_CTRL_BASE: periphTarget = TGT_NORMAL_CTRL;
      ADAPT_SPI_BASE: periphTarget = TGT_ADAPT_SPI;
      UART_BASE: periphTarget = TGT_UART;
      GPIO1_BASE: periphTarget = TGT_GPIO1;
      GPIO2_BASE: periphTarget = TGT_GPIO2;
      BOARD_QSPI_BASE: periphTarget = TGT_BOARD_QSPI;
      default: periphTarget = TGT_NONE;
    endcase
  endfunction

  // priority chain; low alias target depends on adaptor presence
  assign target =
    hitLowAlias ? (adaptorFitted ? TGT_XIP_FLASH : TGT_INSTR_RAM) :
    hitHighAlias ? TGT_INSTR_RAM :
    hitDataRam ? TGT_DATA_RAM :
    hitPeriph ? periphTarget(reqAddr) :
    hitBram ? TGT_BRAM :
    hitWatch ? TGT_WATCH_TRACE :
    hitBreak ? TGT_BREAKPOINT :
    hitSysCtrl ? TGT_SYS_CTRL :
    TGT_NONE;

  // execute-never data RAM, writes to the fixed table, unmapped holes
  logic refuse, localHit;
  assign refuse = (hitDataRam && reqFetch) ||
                  (hitIdTable && reqWrite) ||
                  (target == TGT_NONE && !hitIdTable);
  assign localHit = hitIdTable || (target == TGT_FLASH_SEL_GPIO);

  ////////////////////////////////////////////////////////////////////////
  // transaction sequencing

  typedef enum {ST_IDLE, ST_WAIT} seq_state_t;
  seq_state_t state_reg, state_next;
  target_t target_reg;
  logic localDone, localErr;
  logic [31:0] localRdata;
  logic rspValid_reg, rspErr_reg;
  logic [31:0] rspRdata_reg;
  logic takeReq;

  // a request still held while its answer shows is not taken a second time
  assign takeReq = (state_reg == ST_IDLE) && reqValid && !rspValid_reg;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: if (takeReq && !refuse && !localHit) state_next = ST_WAIT;
      ST_WAIT: if (slaveReady) state_next = ST_IDLE;
    endcase
  end

  // local answers finish in the same cycle the request is taken
  assign localDone = takeReq && (refuse || localHit);
  assign localErr = refuse;

  // select held during the slave wait; one-hot by target code
  assign slaveSel = (state_reg == ST_WAIT && target_reg != TGT_NONE &&
                     target_reg != TGT_FLASH_SEL_GPIO) ? (16'h0001 << target_reg) : 16'h0000;

  always_ff @(posedge mclk or negedge rstSync_reg) begin
    if (!rstSync_reg) begin
      state_reg <= ST_IDLE;
      target_reg <= TGT_NONE;
    end else begin
      state_reg <= state_next;
      if (takeReq) begin
        target_reg <= target;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // identification table and flash select latch

  logic [31:0] idRom [ID_DEPTH];
  logic [$clog2(ID_DEPTH)-1:0] idIndex;
  logic flashSel_reg, flashSel_next;
  logic selWrite;

  // table contents are constants; nothing in the design can write them
  always_comb begin
    for (int i = 0; i < ID_DEPTH; i++) begin
      idRom[i] = ID_WORD_VALUE;
    end
  end
  assign idIndex = reqAddr[$clog2(ID_DEPTH)+1:2];

  // flash select lives in bit 0 of the adaptor GPIO slot
  assign selWrite = takeReq && !refuse && (target == TGT_FLASH_SEL_GPIO) && reqWrite;
  assign flashSel_next = selWrite ? reqWdata[FLASH_SEL_BIT] : flashSel_reg;
  assign localRdata = hitIdTable ? idRom[idIndex] :
                      {{31{1'b0}}, flashSel_reg};

  // reset picks the XIP controller so flash boot can fetch at once
  always_ff @(posedge mclk or negedge rstSync_reg) begin
    if (!rstSync_reg) begin
      flashSel_reg <= FLASH_SEL_RESET;
    end else begin
      flashSel_reg <= flashSel_next;
    end
  end

  // a switch to normal mode while executing from flash locks the core;
  // the decoder cannot tell, so software must avoid it
  assign flashSelNormal = flashSel_reg;

  ////////////////////////////////////////////////////////////////////////
  // response register

  always_ff @(posedge mclk or negedge rstSync_reg) begin
    if (!rstSync_reg) begin
      rspValid_reg <= 1'b0;
      rspErr_reg <= 1'b0;
      rspRdata_reg <= 32'h0000_0000;
    end else begin
      rspValid_reg <= localDone || (state_reg == ST_WAIT && slaveReady);
      rspErr_reg <= localDone ? localErr : slaveErr;
      rspRdata_reg <= localDone ? (localErr ? 32'h0000_0000 : localRdata) : slaveRdata;
    end
  end

  assign rspValid = rspValid_reg;
  assign rspErr = rspErr_reg;
  assign rspRdata = rspRdata_reg;

  ////////////////////////////////////////////////////////////////////////
  // flash pin multiplexer

  flash_mux_if fmBus ();
  assign fmBus.sel = flashSel_reg;
  assign fmBus.xipCsN = xipCsN;
  assign fmBus.xipSck = xipSck;
  assign fmBus.xipDo = xipDo;
  assign fmBus.xipOe = xipOe;
  assign fmBus.normCsN = normCsN;
  assign fmBus.normSck = normSck;
  assign fmBus.normDo = normDo;
  assign fmBus.normOe = normOe;
  assign fmBus.flashDi = flashDi;
  assign xipDi = fmBus.xipDi;
  assign normDi = fmBus.normDi;
  assign flashCsN = fmBus.flashCsN;
  assign flashSck = fmBus.flashSck;
  assign flashDo = fmBus.flashDo;
  assign flashOe = fmBus.flashOe;

  flash_pin_mux flashMux (
    .fm(fmBus.mux)
  );

endmodule
`default_nettype wire

// *** shared/addr_map_pkg.sv ***
/*
  Address map constants, target encoding and boot/flash-select settings
  for the system address decoder.
  Assumes a 32-bit byte address bus from a single processor master.
*/
package addr_map_pkg;
  localparam int ADDR_W = 32;
  // processor-internal code aliases and data RAM
  localparam logic [31:0] INSTR_LOW_BASE = 32'h0000_0000;
  localparam logic [31:0] INSTR_LOW_LAST = 32'h000F_FFFF;
  localparam logic [31:0] INSTR_HIGH_BASE = 32'h1000_0000;
  localparam logic [31:0] INSTR_HIGH_LAST = 32'h100F_FFFF;
  localparam logic [31:0] DATA_RAM_BASE = 32'h2000_0000;
  localparam logic [31:0] DATA_RAM_LAST = 32'h200F_FFFF;
  // peripheral region and adaptor-board peripherals
  localparam logic [31:0] PERIPH_BASE = 32'h4000_0000;
  localparam logic [31:0] PERIPH_LAST = 32'h5FFF_FFFF;
  localparam logic [31:0] XIP_CTRL_BASE = 32'h4000_0000;
  localparam logic [31:0] FLASH_SEL_GPIO_BASE = 32'h4001_0000;
  localparam logic [31:0] NORMAL_CTRL_BASE = 32'h4002_0000;
  localparam logic [31:0] ADAPT_SPI_BASE = 32'h4003_0000;
  localparam logic [31:0] UART_BASE = 32'h4010_0000;
  localparam logic [31:0] GPIO1_BASE = 32'h4011_0000;
  localparam logic [31:0] GPIO2_BASE = 32'h4012_0000;
  localparam logic [31:0] BOARD_QSPI_BASE = 32'h4013_0000;
  localparam logic [31:0] PERIPH_SLOT_MASK = 32'hFFFF_0000;
  // memory region with block RAM
  localparam logic [31:0] MEM_REGION_BASE = 32'h6000_0000;
  localparam logic [31:0] MEM_REGION_LAST = 32'h9FFF_FFFF;
  localparam logic [31:0] BRAM_BASE = 32'h6000_0000;
  localparam logic [31:0] BRAM_LAST = 32'h6000_1FFF;
  // system space windows, 4KB each
  localparam logic [31:0] SYS_WIN_MASK = 32'hFFFF_F000;
  localparam logic [31:0] WATCH_TRACE_BASE = 32'hE000_1000;
  localparam logic [31:0] BREAKPOINT_BASE = 32'hE000_2000;
  localparam logic [31:0] SYS_CTRL_BASE = 32'hE000_E000;
  localparam logic [31:0] ID_TABLE_BASE = 32'hE00F_F000;
  localparam logic [31:0] ID_TABLE_LAST = 32'hE00F_FFFF;
  // alias configuration: bit 0 low alias, bit 1 upper alias (always high)
  localparam int ALIAS_LOW_BIT = 0;
  localparam int ALIAS_HIGH_BIT = 1;
  localparam int FLASH_SEL_BIT = 0;
  localparam logic FLASH_SEL_RESET = 1'b0;
  localparam int PRESENT_IRQ_BIT = 31;
  localparam int IRQ_W = 32;
  localparam int ID_WORDS = 16;
  localparam logic [31:0] ID_WORD_VALUE = 32'h0000_0000; // arbitrary neutral content

  typedef enum logic [3:0] {
    TGT_NONE,
    TGT_INSTR_RAM,
    TGT_XIP_FLASH,
    TGT_DATA_RAM,
    TGT_XIP_CTRL,
    TGT_FLASH_SEL_GPIO,
    TGT_NORMAL_CTRL,
    TGT_ADAPT_SPI,
    TGT_UART,
    TGT_GPIO1,
    TGT_GPIO2,
    TGT_BOARD_QSPI,
    TGT_BRAM,
    TGT_WATCH_TRACE,
    TGT_BREAKPOINT,
    TGT_SYS_CTRL
  } target_t;
endpackage

// *** shared/flash_mux_if.sv ***
/*
  Bundle between decoder and flash pin multiplexer: two controller pin
  sets, the select, and the flash pin set.
  Assumes four data lines with per-line output enables.
*/
`timescale 1ns/10ps
`default_nettype none
interface flash_mux_if;
  logic sel;
  logic xipCsN, xipSck;
  logic [3:0] xipDo, xipOe, xipDi;
  logic normCsN, normSck;
  logic [3:0] normDo, normOe, normDi;
  logic flashCsN, flashSck;
  logic [3:0] flashDo, flashOe, flashDi;
  modport mux (input sel, xipCsN, xipSck, xipDo, xipOe, normCsN, normSck, normDo, normOe,
    flashDi, output xipDi, normDi, flashCsN, flashSck, flashDo, flashOe);
  modport top (output sel, xipCsN, xipSck, xipDo, xipOe, normCsN, normSck, normDo, normOe,
    flashDi, input xipDi, normDi, flashCsN, flashSck, flashDo, flashOe);
endinterface
`default_nettype wire

// *** src/flash_pin_mux.sv ***
/*
  Steers the one flash pin set to exactly one of two controllers.
  Assumes the select is already registered and stable between transfers.
*/
`timescale 1ns/10ps
`default_nettype none
module flash_pin_mux (
  flash_mux_if.mux fm
);
  // select high gives the flash to the normal-mode controller
  assign fm.flashCsN = fm.sel ? fm.normCsN : fm.xipCsN;
  assign fm.flashSck = fm.sel ? fm.normSck : fm.xipSck;
  assign fm.flashDo = fm.sel ? fm.normDo : fm.xipDo;
  assign fm.flashOe = fm.sel ? fm.normOe : fm.xipOe;
  // deselected controller sees idle-high data so it never decodes noise
  assign fm.xipDi = fm.sel ? 4'hF : fm.flashDi;
  assign fm.normDi = fm.sel ? fm.flashDi : 4'hF;
endmodule
`default_nettype wire

// *** verification/slave_model.sv ***
/*
  Stand-in for the memories and peripherals behind the decoder's selects.
  Assumes at most one select is high and that it is held until ready.
*/
`timescale 1ns/10ps
`default_nettype none
module slave_model (
  input wire logic mclk,
  input wire logic [15:0] slaveSel,
  input wire logic [3:0] waitCycles,
  input wire logic errInject,
  output logic slaveReady = 1'b0,
  output logic [31:0] slaveRdata = 32'h0,
  output logic slaveErr = 1'b0
);
  ////////////////////////////////////////////////////////////
  logic [3:0] waitCnt = 4'h0;

  // answer after waitCycles; idle data flips so stale words never match
  always @(posedge mclk) begin
    slaveReady <= 1'b0;
    slaveErr <= 1'b0;
    slaveRdata <= ~slaveRdata;
    if (slaveSel != 16'h0 && !slaveReady) begin
      if (waitCnt == waitCycles) begin
        waitCnt <= 4'h0;
        slaveReady <= 1'b1;
        slaveRdata <= {16'h5A5A, slaveSel};
        slaveErr <= errInject;
      end else begin
        waitCnt <= waitCnt + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// *** verification/system_address_decoder_sva.sv ***
/*
  Port checker for the system address decoder.
  Assumes a master that keeps one request outstanding.
*/
`timescale 1ns/10ps
`default_nettype none
module system_address_decoder_sva
  import addr_map_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic reqValid,
  input wire logic [31:0] reqAddr,
  input wire logic reqWrite,
  input wire logic reqFetch,
  input wire logic [31:0] reqWdata,
  input wire logic [15:0] slaveSel,
  input wire logic slaveReady,
  input wire logic [31:0] slaveRdata,
  input wire logic slaveErr,
  input wire logic rspValid,
  input wire logic [31:0] rspRdata,
  input wire logic rspErr,
  input wire logic [1:0] instrRamAliasConfig,
  input wire logic adaptorPresent_n,
  input wire logic [IRQ_W-2:0] periphIrq,
  input wire logic [IRQ_W-1:0] coreIrq,
  input wire logic flashCsN,
  input wire logic flashSck,
  input wire logic xipCsN,
  input wire logic xipSck,
  input wire logic normCsN,
  input wire logic normSck,
  input wire logic flashSelNormal
);
  ////////////////////////////////////////////////////////////
  logic busyReg;
  target_t expTgt;
  logic [15:0] expSel;
  wire take = reqValid && !busyReg;
  wire selBit = reqWdata[FLASH_SEL_BIT];
  wire inData = reqAddr >= DATA_RAM_BASE && reqAddr <= DATA_RAM_LAST;
  wire inId = reqAddr >= ID_TABLE_BASE && reqAddr <= ID_TABLE_LAST;
  wire inHole = (reqAddr >= 32'h4004_0000 && reqAddr <= 32'h400F_FFFF)
    || (reqAddr > BRAM_LAST && reqAddr <= MEM_REGION_LAST);

  // expected owner of an address; locally answered places give none
  function automatic target_t route(input logic [31:0] a, input logic lowRam);
    target_t t;
    t = TGT_NONE;
    if (a <= INSTR_LOW_LAST) t = lowRam ? TGT_INSTR_RAM : TGT_XIP_FLASH;
    if (a >= INSTR_HIGH_BASE && a <= INSTR_HIGH_LAST) t = TGT_INSTR_RAM;
    if (a >= DATA_RAM_BASE && a <= DATA_RAM_LAST) t = TGT_DATA_RAM;
    if (a >= BRAM_BASE && a <= BRAM_LAST) t = TGT_BRAM;
    case (a & PERIPH_SLOT_MASK)
      XIP_CTRL_BASE: t = TGT_XIP_CTRL;
      NORMAL_CTRL_BASE: t = TGT_NORMAL_CTRL;
      ADAPT_SPI_BASE: t = TGT_ADAPT_SPI;
      UART_BASE: t = TGT_UART;
      GPIO1_BASE: t = TGT_GPIO1;
      GPIO2_BASE: t = TGT_GPIO2;
      BOARD_QSPI_BASE: t = TGT_BOARD_QSPI;
      default: ;
    endcase
    case (a & SYS_WIN_MASK)
      WATCH_TRACE_BASE: t = TGT_WATCH_TRACE;
      BREAKPOINT_BASE: t = TGT_BREAKPOINT;
      SYS_CTRL_BASE: t = TGT_SYS_CTRL;
      default: ;
    endcase
    return t;
  endfunction

  // data-ram fetches are excluded so these refused fetches fall outside this map
  assign expTgt = reqFetch && inData ? TGT_NONE : route(reqAddr, instrRamAliasConfig[0]);
  assign expSel = (expTgt == TGT_NONE) ? 16'h0 : 16'h1 << expTgt;

  // one outstanding request: busy from take until the answer
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      busyReg <= 1'b0;
    end else begin
      busyReg <= take || (busyReg && !rspValid);
    end
  end
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_localErr;
    rspValid && rspErr && rspRdata == 32'h0 && slaveSel == 16'h0;
  endsequence
  sequence s_selWrite;
    take && reqWrite && (reqAddr & PERIPH_SLOT_MASK) == FLASH_SEL_GPIO_BASE;
  endsequence

  property p_route;
    take && expTgt != TGT_NONE |=> slaveSel == $past(expSel);
  endproperty
  a_route: assert property (p_route)
    else $error("slave select does not match address");
  property p_fetchRefuse;
    take && reqFetch && inData |=> s_localErr;
  endproperty
  a_fetchRefuse: assert property (p_fetchRefuse)
    else $error("fetch from data ram not refused");
  property p_idWrite;
    take && reqWrite && inId |=> s_localErr;
  endproperty
  a_idWrite: assert property (p_idWrite)
    else $error("id table write not refused");
  property p_idRead;
    take && !reqWrite && inId |=> rspValid && !rspErr && rspRdata == ID_WORD_VALUE;
  endproperty
  a_idRead: assert property (p_idRead)
    else $error("id table read wrong");
  property p_unmapped;
    take && inHole |=> s_localErr;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access without bus error");
  property p_selWrite;
    s_selWrite |=> rspValid && !rspErr ##1 flashSelNormal == $past(selBit, 2);
  endproperty
  a_selWrite: assert property (p_selWrite)
    else $error("flash select not written");
  property p_slaveResp;
    slaveReady && slaveSel != 16'h0 |=> rspValid && slaveSel == 16'h0
      && rspRdata == $past(slaveRdata) && rspErr == $past(slaveErr);
  endproperty
  a_slaveResp: assert property (p_slaveResp)
    else $error("slave answer not forwarded");
  property p_aliasPair;
    instrRamAliasConfig == {1'b1, coreIrq[PRESENT_IRQ_BIT]} && coreIrq[IRQ_W-2:0] == periphIrq;
  endproperty
  a_aliasPair: assert property (p_aliasPair)
    else $error("alias bits or interrupt lines wrong");
  property p_presence;
    $stable(adaptorPresent_n) [*8] |-> coreIrq[PRESENT_IRQ_BIT] == adaptorPresent_n;
  endproperty
  a_presence: assert property (p_presence)
    else $error("presence level not on line 31");
  property p_mux;
    flashCsN == (flashSelNormal ? normCsN : xipCsN) && flashSck == (flashSelNormal ? normSck : xipSck);
  endproperty
  a_mux: assert property (p_mux)
    else $error("flash pins follow wrong controller");
endmodule

bind system_address_decoder system_address_decoder_sva system_address_decoder_sva_inst (.mclk,
  .rst_n, .reqValid, .reqAddr, .reqWrite, .reqFetch, .reqWdata, .slaveSel, .slaveReady,
  .slaveRdata, .slaveErr, .rspValid, .rspRdata, .rspErr, .instrRamAliasConfig, .adaptorPresent_n,
  .periphIrq, .coreIrq, .flashCsN, .flashSck, .xipCsN, .xipSck, .normCsN, .normSck, .flashSelNormal);
`default_nettype wire

// *** verification/tb_top.sv ***
/*
  Self-checking bench for the system address decoder.
  Assumes the slave model answers every select.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import addr_map_pkg::*;
;
  logic mclk, rst_n, reqValid, reqWrite, reqFetch, slaveReady, slaveErr, rspValid, rspErr;
  logic [31:0] reqAddr, reqWdata, slaveRdata, rspRdata, gotData;
  logic [15:0] slaveSel, gotSel;
  logic [1:0] instrRamAliasConfig;
  logic adaptorPresent_n, flashCsN, flashSck, xipCsN, xipSck, normCsN, normSck;
  logic flashSelNormal, errInject, gotErr;
  logic [30:0] periphIrq;
  logic [31:0] coreIrq;
  logic [3:0] flashDo, flashOe, flashDi, xipDo, xipOe, xipDi, normDo, normOe, normDi, waitCycles;
  logic [3:0] slowness;
  int failures, checksDone;

  system_address_decoder system_address_decoder_inst (.mclk, .rst_n, .reqValid, .reqAddr,
    .reqWrite, .reqFetch, .reqWdata, .slaveSel, .slaveReady, .slaveRdata, .slaveErr, .rspValid,
    .rspRdata, .rspErr, .instrRamAliasConfig, .adaptorPresent_n, .periphIrq, .coreIrq, .flashCsN,
    .flashSck, .flashDo, .flashOe, .flashDi, .xipCsN, .xipSck, .xipDo, .xipOe, .xipDi, .normCsN,
    .normSck, .normDo, .normOe, .normDi, .flashSelNormal);
  slave_model slave_model_inst (.mclk, .slaveSel, .waitCycles, .errInject, .slaveReady,
    .slaveRdata, .slaveErr);
  ////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d failures %0d", checksDone, failures);
    if (failures == 0 && checksDone > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one request held until its answer, dropped on the edge closing it
  task automatic bus(input logic [31:0] a, input logic wr, input logic fe, input logic [31:0] wd);
    int n;
    gotSel = 16'h0;
    n = 0;
    @(posedge mclk);
    reqValid <= 1'b1;
    reqAddr <= a;
    reqWrite <= wr;
    reqFetch <= fe;
    reqWdata <= wd;
    waitCycles <= slowness;
    do begin
      @(posedge mclk);
      #1;
      gotSel = gotSel | slaveSel;
      n++;
    end while (rspValid !== 1'b1 && n < 60);
    if (n >= 60) begin
      failures++;
      final_report();
    end
    gotData = rspRdata;
    gotErr = rspErr;
    @(posedge mclk);
    reqValid <= 1'b0;
    #1;
  endtask

  task automatic hit(input logic [31:0] a, input logic fe, input target_t t);
    logic [15:0] s;
    s = (t == TGT_NONE) ? 16'h0 : 16'h1 << t;
    bus(a, 1'b0, fe, 32'h0);
    check({16'h0, gotSel}, {16'h0, s});
    check({31'h0, gotErr}, {31'h0, t == TGT_NONE});
    check(gotData, (t == TGT_NONE) ? 32'h0 : {16'h5A5A, s});
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_bootNoAdaptor();
    check({30'h0, instrRamAliasConfig}, 32'h3);
    check({31'h0, coreIrq[31]}, 32'h1);
    hit(32'h0000_0000, 1'b1, TGT_INSTR_RAM);
    hit(32'h1000_0000, 1'b0, TGT_INSTR_RAM);
  endtask

  task automatic t_map();
    logic [31:0] addrs [18] = '{32'h6000_0000, 32'h6000_1FFC, 32'h6000_2000, 32'hA000_0000,
      32'hE000_1000, 32'hE000_2FFC, 32'hE000_E000, 32'hE000_3000, 32'h2000_0000, 32'h4000_0000,
      32'h4002_0000, 32'h4003_0000, 32'h4010_0000, 32'h4011_0000, 32'h4012_FFFC, 32'h4013_0000,
      32'h4004_0000, 32'h5FFF_FFFC};
    target_t tgts [18] = '{TGT_BRAM, TGT_BRAM, TGT_NONE, TGT_NONE, TGT_WATCH_TRACE,
      TGT_BREAKPOINT, TGT_SYS_CTRL, TGT_NONE, TGT_DATA_RAM, TGT_XIP_CTRL, TGT_NORMAL_CTRL,
      TGT_ADAPT_SPI, TGT_UART, TGT_GPIO1, TGT_GPIO2, TGT_BOARD_QSPI, TGT_NONE, TGT_NONE};
    for (int i = 0; i < 18; i++) begin
      slowness = 4'(i % 8);
      hit(addrs[i], i == 1, tgts[i]);
    end
    errInject <= 1'b1;
    bus(UART_BASE, 1'b1, 1'b0, 32'h1234_5678);
    check({31'h0, gotErr}, 32'h1);
    errInject <= 1'b0;
  endtask

  task automatic t_refuse();
    hit(32'h2000_0000, 1'b1, TGT_NONE);
    bus(ID_TABLE_LAST - 32'h3, 1'b1, 1'b0, 32'hFFFF_FFFF);
    check({31'h0, gotErr}, 32'h1);
    bus(ID_TABLE_BASE, 1'b0, 1'b0, 32'h0);
    check({gotSel, 15'h0, gotErr}, 32'h0);
    check(gotData, ID_WORD_VALUE);
  endtask

  task automatic t_flashSel();
    @(posedge mclk);
    xipCsN <= 1'b0;
    normCsN <= 1'b1;
    xipSck <= 1'b1;
    xipDo <= 4'h5;
    normDo <= 4'hA;
    xipOe <= 4'h3;
    normOe <= 4'hC;
    flashDi <= 4'h6;
    bus(FLASH_SEL_GPIO_BASE, 1'b0, 1'b0, 32'h0);
    check(gotData, 32'h0);
    check({18'h0, flashCsN, flashSck, flashDo, flashOe, xipDi},
      {18'h0, 1'b0, 1'b1, 4'h5, 4'h3, 4'h6});
    bus(FLASH_SEL_GPIO_BASE, 1'b1, 1'b0, 32'h1);
    check({17'h0, flashSelNormal, flashCsN, flashSck, flashDo, flashOe, normDi},
      {17'h0, 1'b1, 1'b1, 1'b0, 4'hA, 4'hC, 4'h6});
    bus(FLASH_SEL_GPIO_BASE, 1'b0, 1'b0, 32'h0);
    check(gotData, 32'h1);
    // hand the flash back to execute-in-place before code runs from it
    bus(FLASH_SEL_GPIO_BASE, 1'b1, 1'b0, 32'h0);
    check({31'h0, flashSelNormal}, 32'h0);
  endtask

  task automatic t_adaptor();
    @(posedge mclk);
    adaptorPresent_n <= 1'b0;
    periphIrq <= 31'h2AAA_5555;
    repeat (10) @(posedge mclk);
    #1;
    check({30'h0, instrRamAliasConfig}, 32'h2);
    check(coreIrq, 32'h2AAA_5555);
    hit(32'h0000_0000, 1'b1, TGT_XIP_FLASH);
    hit(32'h1000_0000, 1'b1, TGT_INSTR_RAM);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // reset, then let the release flops and presence sync settle
  initial begin
    {rst_n, reqValid, reqWrite, reqFetch, errInject, xipSck, normSck} = '0;
    {xipCsN, normCsN, adaptorPresent_n} = 3'h7;
    {reqAddr, reqWdata, periphIrq} = '0;
    {xipDo, xipOe, normDo, normOe, flashDi, waitCycles, slowness} = '0;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (8) @(posedge mclk);
    t_bootNoAdaptor();
    t_map();
    t_refuse();
    t_flashSel();
    t_adaptor();
    final_report();
  end
endmodule
`default_nettype wire
